// ### verilog/esm_top.sv
// Function
// - the function can be enabled only at port rates of 10 Gbps or less
// - when enabled, count received levels and alarm on missing messages
// - monitor mode receives and tracks quality level, never transmits
// - monitor mode never locks timing to the recovered reference
// - synchronous mode sends one message per second with configured level
// - naming option only relabels codes; sent and received codes unchanged
// - transmit configured source mac, or fixed default when default chosen
// - capture records messages with the frame check sequence stripped
`timescale 1ns/1ps
`default_nettype none
`include "esm_regs.svh"
module esm_top #(
  parameter int CYC_PER_SEC = `ESM_SEC_NS / `ESM_CLK_NS,
  // value is arbitrary, locally administered
  parameter logic [47:0] DEFAULT_MAC = 48'h020000000001
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire esm_pkg::esm_cfg_t cfg_in,
  input wire logic [3:0] stat_sel_in,
  // received frames, fcs included, rx_good_in qualifies the last byte
  input wire esm_pkg::esm_byte_t rx_in,
  input wire logic rx_good_in,
  // transmitted messages
  output esm_pkg::esm_byte_t tx_out,
  input wire logic tx_ready_in,
  // capture stream
  output esm_pkg::esm_byte_t cap_out,
  // status
  output logic sync_enabled_out,
  output logic sync_alarm_out,
  output logic lock_to_ref_out,
  output logic rx_msg_out,
  output logic [3:0] rx_ql_out,
  output logic rx_event_out,
  output esm_pkg::esm_naming_t naming_out,
  output logic [15:0] stat_count_out
);
  // the second counter is 26 bits wide, so larger rates cannot be served
  if (CYC_PER_SEC < 2 || CYC_PER_SEC > (1 << 26)) begin : g_cps_check
    $error("CYC_PER_SEC out of range");
  end

  esm_pkg::esm_top_st_t s_q, s_d;
  logic [15:0] stat_mem [16];
  logic tick, tx_start, tx_busy, ev_w, msg_w;
  logic [47:0] mac_w;

  always_comb begin
    s_d = s_q;
    s_d.en = cfg_in.enable &&
             (cfg_in.rate_mbps <= `ESM_MAX_RATE_MBPS);
    s_d.sync = cfg_in.sync_mode;
    s_d.lock = s_d.en && cfg_in.sync_mode;
    s_d.naming = cfg_in.quality_level_naming_option;
    tick = (s_q.sec_cnt == 26'(CYC_PER_SEC - 1));
    s_d.sec_cnt = tick ? 26'h0000000 : s_q.sec_cnt + 26'h0000001;

    // transmit side, only in synchronous mode
    tx_start = tick && s_q.en && s_q.sync && !tx_busy;
    mac_w = cfg_in.mac_default ? DEFAULT_MAC :
            cfg_in.source_mac_address;
    unique case (cfg_in.event_policy)
      esm_pkg::ESM_EV_STATIC_ON: ev_w = 1'b1;
      esm_pkg::ESM_EV_STATIC_OFF: ev_w = 1'b0;
      default: ev_w = !s_q.first_sent;
    endcase
    if (!(s_q.en && s_q.sync)) begin
      s_d.first_sent = 1'b0;
    end else if (tx_start) begin
      s_d.first_sent = 1'b1;
    end

    // receive parser
    msg_w = 1'b0;
    s_d.rx_msg = 1'b0;
    if (rx_in.valid) begin
      if (esm_pkg::esm_is_fixed(s_q.rx_idx) &&
          rx_in.data != esm_pkg::esm_fixed_byte(s_q.rx_idx)) begin
        s_d.rx_ok = 1'b0;
      end
      if (s_q.rx_idx == `ESM_IDX_FLAGS) begin
        s_d.rx_ev = rx_in.data[`ESM_EVENT_BIT];
      end
      if (s_q.rx_idx == `ESM_IDX_SSM) begin
        s_d.rx_ssm = rx_in.data[3:0];
      end
      if (s_q.rx_idx != 7'h7F) begin
        s_d.rx_idx = s_q.rx_idx + 7'h01;
      end
      if (rx_in.last) begin
        msg_w = s_d.rx_ok && rx_good_in && s_q.en &&
                (s_q.rx_idx > `ESM_IDX_SSM);
        s_d.rx_idx = 7'h00;
        s_d.rx_ok = 1'b1;
      end
    end
    if (msg_w) begin
      s_d.rx_msg = 1'b1;
      s_d.rx_ql = s_d.rx_ssm;
      s_d.rx_event = s_d.rx_ev;
    end

    // loss of messages, counted in whole seconds
    if (!s_d.en) begin
      s_d.miss = 3'h0;
      s_d.alarm = 1'b0;
    end else if (msg_w) begin
      s_d.miss = 3'h0;
      s_d.alarm = 1'b0;
    end else if (tick && s_q.miss != `ESM_MISS_SECS) begin
      s_d.miss = s_q.miss + 3'h1;
      s_d.alarm = (s_q.miss + 3'h1 == `ESM_MISS_SECS);
    end

    // capture holds back four bytes so the fcs is never released
    s_d.cap.valid = 1'b0;
    s_d.cap.last = 1'b0;
    if (rx_in.valid) begin
      if (s_q.rx_idx == 7'h00) begin
        s_d.cap_frame = s_q.en && cfg_in.capture;
      end
      s_d.cap_pipe = {s_q.cap_pipe[23:0], rx_in.data};
      if (s_q.cap_fill == `ESM_FCS_LEN) begin
        s_d.cap.valid = s_d.cap_frame;
        s_d.cap.data = s_q.cap_pipe[31:24];
        s_d.cap.last = rx_in.last;
      end else begin
        s_d.cap_fill = s_q.cap_fill + 3'h1;
      end
      if (rx_in.last) begin
        s_d.cap_fill = 3'h0;
      end
    end
    s_d.stat = stat_mem[stat_sel_in];
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.rx_ok <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // per-code message counters, saturating so a long run never wraps
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) begin
        stat_mem[i] <= 16'h0000;
      end
    end else if (msg_w && stat_mem[s_d.rx_ssm] != 16'hFFFF) begin
      stat_mem[s_d.rx_ssm] <= stat_mem[s_d.rx_ssm] + 16'h0001;
    end
  end

  esm_tx u_tx (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(tx_start),
    .sa_in(mac_w),
    .event_in(ev_w),
    .ql_in(cfg_in.ql),
    .busy_out(tx_busy),
    .tx_out(tx_out),
    .tx_ready_in(tx_ready_in)
  );

  assign cap_out = s_q.cap;
  assign sync_enabled_out = s_q.en;
  assign sync_alarm_out = s_q.alarm;
  assign lock_to_ref_out = s_q.lock;
  assign rx_msg_out = s_q.rx_msg;
  assign rx_ql_out = s_q.rx_ql;
  assign rx_event_out = s_q.rx_event;
  assign naming_out = s_q.naming;
  assign stat_count_out = s_q.stat;

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_rate_gate: assert property (
    (cfg_in.rate_mbps > `ESM_MAX_RATE_MBPS) |=> !sync_enabled_out)
    else $error("enabled above rate limit");
  a_alarm_needs_en: assert property (
    !sync_enabled_out |-> !sync_alarm_out)
    else $error("alarm while disabled");
  a_monitor_silent: assert property (
    !s_q.sync |-> ##1 !(tx_out.valid && !$past(tx_out.valid)) )
    else $error("frame started in monitor mode");
  a_no_lock_monitor: assert property (
    !cfg_in.sync_mode |=> !lock_to_ref_out)
    else $error("locked in monitor mode");
  a_one_per_sec: assert property (
    tx_start |=> (s_q.sec_cnt == 26'h0000000) && !tx_start)
    else $error("send not on second tick");
  a_ql_only_on_msg: assert property (
    $changed(rx_ql_out) |-> rx_msg_out)
    else $error("received level changed without message");
  // checked on what the sender latched, not on the selection itself
  a_mac_default: assert property (
    (tx_start && cfg_in.mac_default) |=> (u_tx.s_q.sa == DEFAULT_MAC))
    else $error("default mac not used");
  a_event_dynamic: assert property (
    (tx_start && cfg_in.event_policy == esm_pkg::ESM_EV_DYNAMIC &&
     s_q.first_sent) |=> !u_tx.s_q.event_flag)
    else $error("dynamic event flag set after first");
  a_cap_strip: assert property (
    (cap_out.valid && cap_out.last) |-> $past(rx_in.valid && rx_in.last))
    else $error("capture end not aligned to frame end");
  a_alarm_clear: assert property (
    msg_w |=> !sync_alarm_out ##0 (s_q.miss == 3'h0))
    else $error("alarm not cleared by message");
  // a disable in the same cycle clears instead, so it is left out here
  a_alarm_raise: assert property (
    (tick && s_d.en && !msg_w && s_q.miss == `ESM_MISS_SECS - 3'h1)
    |=> sync_alarm_out)
    else $error("alarm missed after five seconds");
endmodule // esm_top
`default_nettype wire

// ### verilog/esm_regs.svh
`ifndef ESM_REGS_SVH
`define ESM_REGS_SVH

// timing
`define ESM_SEC_NS 1000000000
`define ESM_CLK_NS 20
`define ESM_MISS_SECS 3'h5

// rate gate, in Mbit/s
`define ESM_MAX_RATE_MBPS 17'h02710

// frame layout, byte indices without preamble and FCS
`define ESM_FRAME_LEN 7'h3C
`define ESM_HDR_LAST 7'h1A
`define ESM_SA_FIRST 7'h06
`define ESM_SA_LAST 7'h0B
`define ESM_IDX_FLAGS 7'h14
`define ESM_IDX_SSM 7'h1B
`define ESM_FCS_LEN 3'h4

// fixed field values
`define ESM_DA 48'h0180C2000002
`define ESM_ETHERTYPE 16'h8809
`define ESM_SLOW_SUBTYPE 8'h0A
`define ESM_OUI 24'h0019A7
`define ESM_ITU_SUBTYPE 16'h0001
`define ESM_TLV_QL 8'h01
`define ESM_TLV_LEN 16'h0004
`define ESM_VERSION 4'h1
`define ESM_EVENT_BIT 3

`endif

// ### verilog/esm_pkg.sv
`default_nettype none
package esm_pkg;
  `include "esm_regs.svh"

  typedef enum logic [1:0] {
    ESM_EV_DYNAMIC = 2'h0,
    ESM_EV_STATIC_OFF = 2'h1,
    ESM_EV_STATIC_ON = 2'h2
  } esm_event_t;

  typedef enum logic [1:0] {
    ESM_NAME_G781_OPT1 = 2'h0,
    ESM_NAME_G781_OPT2 = 2'h1,
    ESM_NAME_G781_OPT3 = 2'h2,
    ESM_NAME_G8264 = 2'h3
  } esm_naming_t;

  typedef enum logic [1:0] {
    ESM_TX_IDLE = 2'h1,
    ESM_TX_SEND = 2'h2
  } esm_tx_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } esm_byte_t;

  typedef struct packed {
    logic enable;
    logic sync_mode;
    logic [16:0] rate_mbps;
    logic [3:0] ql;
    esm_naming_t quality_level_naming_option;
    logic mac_default;
    logic [47:0] source_mac_address;
    esm_event_t event_policy;
    logic capture;
  } esm_cfg_t;

  typedef struct packed {
    esm_tx_state_t state;
    logic [6:0] idx;
    logic [47:0] sa;
    logic event_flag;
    logic [3:0] ssm;
    esm_byte_t out;
  } esm_tx_st_t;

  typedef struct packed {
    logic en;
    logic sync;
    logic [25:0] sec_cnt;
    logic [2:0] miss;
    logic alarm;
    logic lock;
    logic first_sent;
    logic [6:0] rx_idx;
    logic rx_ok;
    logic [3:0] rx_ssm;
    logic rx_ev;
    logic rx_msg;
    logic [3:0] rx_ql;
    logic rx_event;
    esm_naming_t naming;
    logic cap_frame;
    logic [2:0] cap_fill;
    logic [31:0] cap_pipe;
    esm_byte_t cap;
    logic [15:0] stat;
  } esm_top_st_t;

  // fixed header bytes, shared by the sender and the receive checker
  function automatic logic [7:0] esm_fixed_byte(input logic [6:0] idx);
    logic [215:0] hdr;
    hdr = {`ESM_DA, 48'h000000000000, `ESM_ETHERTYPE, `ESM_SLOW_SUBTYPE,
           `ESM_OUI, `ESM_ITU_SUBTYPE, 8'h00, 24'h000000, `ESM_TLV_QL,
           `ESM_TLV_LEN};
    esm_fixed_byte = 8'h00;
    if (idx <= `ESM_HDR_LAST) begin
      esm_fixed_byte = hdr[8 * int'(`ESM_HDR_LAST - idx) +: 8];
    end
  endfunction

  function automatic logic esm_is_fixed(input logic [6:0] idx);
    esm_is_fixed = (idx <= `ESM_HDR_LAST) && (idx != `ESM_IDX_FLAGS) &&
                   !((idx >= `ESM_SA_FIRST) && (idx <= `ESM_SA_LAST));
  endfunction
endpackage
`default_nettype wire

// ### verilog/esm_tx.sv
`timescale 1ns/1ps
`default_nettype none
`include "esm_regs.svh"
module esm_tx (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // message request
  input wire logic start_in,
  input wire logic [47:0] sa_in,
  input wire logic event_in,
  input wire logic [3:0] ql_in,
  output logic busy_out,
  // byte stream to the mac, fcs appended downstream
  output esm_pkg::esm_byte_t tx_out,
  input wire logic tx_ready_in
);
  esm_pkg::esm_tx_st_t s_q, s_d;
  logic take;
  logic [7:0] byte_w;

  always_comb begin
    s_d = s_q;
    take = !s_q.out.valid || tx_ready_in;
    byte_w = esm_pkg::esm_fixed_byte(s_q.idx);
    if (!esm_pkg::esm_is_fixed(s_q.idx)) begin
      if (s_q.idx >= `ESM_SA_FIRST && s_q.idx <= `ESM_SA_LAST) begin
        byte_w = s_q.sa[8 * int'(`ESM_SA_LAST - s_q.idx) +: 8];
      end else if (s_q.idx == `ESM_IDX_FLAGS) begin
        byte_w = 8'h00;
        byte_w[7:4] = `ESM_VERSION;
        byte_w[`ESM_EVENT_BIT] = s_q.event_flag;
      end else if (s_q.idx == `ESM_IDX_SSM) begin
        byte_w = {4'h0, s_q.ssm};
      end else begin
        byte_w = 8'h00;
      end
    end
    if (tx_ready_in) begin
      s_d.out.valid = 1'b0;
    end
    unique case (s_q.state)
      esm_pkg::ESM_TX_IDLE: begin
        if (start_in && !s_q.out.valid) begin
          s_d.state = esm_pkg::ESM_TX_SEND;
          s_d.idx = 7'h00;
          s_d.sa = sa_in;
          s_d.event_flag = event_in;
          s_d.ssm = ql_in;
        end
      end
      esm_pkg::ESM_TX_SEND: begin
        if (take) begin
          s_d.out.valid = 1'b1;
          s_d.out.data = byte_w;
          s_d.out.last = (s_q.idx == `ESM_FRAME_LEN - 7'h01);
          s_d.idx = s_q.idx + 7'h01;
          if (s_q.idx == `ESM_FRAME_LEN - 7'h01) begin
            s_d.state = esm_pkg::ESM_TX_IDLE;
          end
        end
      end
      default: s_d.state = esm_pkg::ESM_TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
      s_q.state <= esm_pkg::ESM_TX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_out = (s_q.state != esm_pkg::ESM_TX_IDLE) || s_q.out.valid;
  assign tx_out = s_q.out;

  // the quality code never spills into the upper nibble
  a_ssm_nibble: assert property (
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (s_q.state == esm_pkg::ESM_TX_SEND && take && s_q.idx == `ESM_IDX_SSM)
    |=> (tx_out.data == {4'h0, $past(s_q.ssm)}))
    else $error("ssm byte malformed");
endmodule // esm_tx
`default_nettype wire

// ### sim/esm_peer.sv
`timescale 1ns/1ps
`default_nettype none
`include "esm_regs.svh"
module esm_peer (
  // clock
  input wire logic sys_clk_in,
  // messages leaving the block
  input wire esm_pkg::esm_byte_t tx_in,
  output logic tx_ready_out,
  // frames entering the block
  output esm_pkg::esm_byte_t rx_out,
  output logic rx_good_out
);
  logic [7:0] txb [0:63];
  logic slow = 1'b0;
  int nb = 0;
  int len = 0;
  int frames = 0;
  int cyc = 0;
  int t_start = 0;
  int t_prev = 0;

  initial begin
    rx_out = '0;
    rx_good_out = 1'b0;
  end

  // stalls on every other cycle when slow, changes on the falling edge
  always @(negedge sys_clk_in) begin
    cyc <= cyc + 1;
  end
  assign tx_ready_out = !slow || cyc[0];

  always @(posedge sys_clk_in) begin
    if (tx_in.valid && tx_ready_out) begin
      if (nb == 0) begin
        t_prev <= t_start;
        t_start <= cyc;
      end
      txb[nb[5:0]] <= tx_in.data;
      nb <= tx_in.last ? 0 : nb + 1;
      if (tx_in.last) begin
        len <= nb + 1;
        frames <= frames + 1;
      end
    end
  end

  // one message with fcs; the line shows a changed value once idle
  task automatic send_frame(input logic [3:0] ql, input logic ev,
                            input logic good);
    logic [215:0] hdr;
    hdr = {`ESM_DA, 48'h02AABBCCDDEE, `ESM_ETHERTYPE, `ESM_SLOW_SUBTYPE,
           `ESM_OUI, `ESM_ITU_SUBTYPE, `ESM_VERSION, ev, 3'h0, 24'h000000,
           `ESM_TLV_QL, `ESM_TLV_LEN};
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk_in);
      rx_out.valid = 1'b1;
      rx_out.data = (i < 27) ? hdr[8 * (26 - i) +: 8] :
                    (i == 27) ? {4'h0, ql} : (i < 60) ? 8'h00 : 8'h5A;
      rx_out.last = (i == 63);
      rx_good_out = good;
    end
    @(negedge sys_clk_in);
    rx_out.valid = 1'b0;
    rx_out.last = 1'b0;
    rx_out.data = ~rx_out.data;
    rx_good_out = ~good;
  endtask
endmodule // esm_peer
`default_nettype wire

// ### sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int CPS = 200;
  // value is arbitrary
  localparam logic [47:0] DMAC = 48'h02000000ABCD;
  localparam logic [47:0] MAC = 48'h02123456789A;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  esm_pkg::esm_cfg_t cfg = '0;
  logic [3:0] sel = 4'hB;
  esm_pkg::esm_byte_t rx, tx, cap;
  esm_pkg::esm_naming_t nm;
  logic rx_good, tx_ready, en_o, alarm, lock, msg, ev_o;
  logic [3:0] ql_o;
  logic [15:0] stat;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  int msgs = 0;
  int caps = 0;
  int ends = 0;
  int fcs_seen = 0;
  int n;

  always #10 sys_clk_in = ~sys_clk_in;

  esm_top #(.CYC_PER_SEC(CPS), .DEFAULT_MAC(DMAC)) esm_top_i (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg),
    .stat_sel_in(sel), .rx_in(rx), .rx_good_in(rx_good), .tx_out(tx),
    .tx_ready_in(tx_ready), .cap_out(cap), .sync_enabled_out(en_o),
    .sync_alarm_out(alarm), .lock_to_ref_out(lock), .rx_msg_out(msg),
    .rx_ql_out(ql_o), .rx_event_out(ev_o), .naming_out(nm),
    .stat_count_out(stat));

  esm_peer esm_peer_i (.sys_clk_in(sys_clk_in), .tx_in(tx),
    .tx_ready_out(tx_ready), .rx_out(rx), .rx_good_out(rx_good));

  task automatic print_verdict();
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (msg === 1'b1) msgs <= msgs + 1;
    if (cap.valid === 1'b1) caps <= caps + 1;
    if (cap.valid === 1'b1 && cap.last === 1'b1) ends <= ends + 1;
    // only the check sequence of the peer's frames carries this byte
    if (cap.valid === 1'b1 && cap.data === 8'h5A) fcs_seen <= fcs_seen + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge sys_clk_in);
  endtask

  task automatic rx_frame(input logic ev, input logic good, input int cnt);
    int m, c, e;
    m = msgs;
    c = caps;
    e = ends;
    esm_peer_i.send_frame(good ? 4'hB : 4'h5, ev, good);
    tick(3);
    check("msg", msgs - m, good);
    check("cap", caps - c, cfg.capture ? 60 : 0);
    check("cap_end", ends - e, cfg.capture ? 1 : 0);
    check("cap_fcs", fcs_seen, 0);
    check("stat", stat, cnt);
    check("rx_ql", ql_o, 4'hB);
    check("rx_ev", ev_o, good ? ev : 1'b1);
  endtask

  task automatic check_tx(input logic [47:0] mac, input logic ev,
                          input logic [3:0] ql);
    int i;
    i = 0;
    n = esm_peer_i.frames;
    while (esm_peer_i.frames == n && i < 400) begin
      tick(1);
      i++;
    end
    check("frame", esm_peer_i.frames - n, 1);
    check("sa", {esm_peer_i.txb[6], esm_peer_i.txb[7], esm_peer_i.txb[8],
      esm_peer_i.txb[9], esm_peer_i.txb[10],
      esm_peer_i.txb[11]}, mac);
    check("flags", esm_peer_i.txb[20], {4'h1, ev, 3'h0});
    check("tx_ql", esm_peer_i.txb[27], {4'h0, ql});
    check("len", esm_peer_i.len, 60);
  endtask

  initial begin
    tick(3);
    rst_n_in = 1'b1;
    check("alarm", alarm, 0);
    cfg.enable = 1'b1;
    cfg.capture = 1'b1;
    cfg.rate_mbps = 17'h02711;
    cfg.quality_level_naming_option = esm_pkg::ESM_NAME_G8264;
    tick(2);
    check("en", en_o, 0);
    cfg.rate_mbps = 17'h02710;
    tick(2);
    check("en", en_o, 1);
    check("lock", lock, 0);
    check("naming", nm, esm_pkg::ESM_NAME_G8264);
    rx_frame(1'b1, 1'b1, 1);
    rx_frame(1'b0, 1'b0, 1);
    sel = 4'h5;
    tick(2);
    check("stat5", stat, 0);
    sel = 4'hB;
    cfg.quality_level_naming_option = esm_pkg::ESM_NAME_G781_OPT1;
    rx_frame(1'b0, 1'b1, 2);
    check("naming", nm, esm_pkg::ESM_NAME_G781_OPT1);
    tick(4 * CPS - 10);
    check("alarm", alarm, 0);
    tick(CPS + 20);
    check("alarm", alarm, 1);
    check("no_tx", esm_peer_i.frames, 0);
    cfg.capture = 1'b0;
    rx_frame(1'b0, 1'b1, 3);
    check("alarm", alarm, 0);
    // synchronous mode with the sink stalling
    esm_peer_i.slow = 1'b1;
    cfg.sync_mode = 1'b1;
    cfg.ql = 4'h7;
    cfg.source_mac_address = MAC;
    tick(2);
    check("lock", lock, 1);
    check_tx(MAC, 1'b1, 4'h7);
    check_tx(MAC, 1'b0, 4'h7);
    check("period", esm_peer_i.t_start - esm_peer_i.t_prev, CPS);
    cfg.mac_default = 1'b1;
    for (int p = 1; p < 3; p++) begin
      cfg.event_policy = esm_pkg::esm_event_t'(p);
      cfg.ql = (p == 1) ? 4'h0 : 4'hF;
      check_tx(DMAC, p == 2, cfg.ql);
    end
    cfg.enable = 1'b0;
    tick(2);
    check("en", en_o, 0);
    check("lock", lock, 0);
    n = esm_peer_i.frames;
    tick(CPS + 10);
    check("off_tx", esm_peer_i.frames - n, 0);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
